// file: src/power_on_reset_sequencer.sv
// Power-on reset sequencer: holds the device in reset until the five
// monitored supplies are good, stretches reset by a pin-selected width,
// then gates configuration and user-mode output enables.
// Assumes supply-good and pin inputs are asynchronous to sys_clk, and
// that the configuration engine reports done and error as same-clock levels.
//
// Overview of operation
// RL1 - Reset follows five monitored supply-good indications.
// RL2 - I/O, PLL, clock-input, battery supplies ignored.
// RL3 - Select low stretches reset to 100 ms.
// RL4 - Select high stretches reset to 12 ms.
// RL5 - External flash ready within long stretch.
// RL6 - Circuits held reset until supplies good.
// RL7 - Every release starts unconfigured, needs reload.
// RL8 - Configure through exactly one of four schemes.
// RL9 - User outputs disabled until user mode.
// RL10 - Supply drop restarts count, reasserts reset.
`timescale 1ns/100ps
module power_on_reset_sequencer
   import por_seq_pkg::*;
#(
   // Stretch lengths in cycles. Silicon keeps the package defaults; a bench may
   // scale them down so that both widths can run in full in a short simulation.
   parameter logic [por_seq_pkg::CNT_W-1:0] LONG_CYC  = por_seq_pkg::LONG_STRETCH_CYC,
   parameter logic [por_seq_pkg::CNT_W-1:0] SHORT_CYC = por_seq_pkg::SHORT_STRETCH_CYC
)
(
   input  wire logic                            sys_clk,
   input  wire logic                            rst,
   input  wire logic [por_seq_pkg::NUM_SUPPLIES-1:0] supplyGood,
   input  wire logic                            reset_delay_select,
   input  wire logic [1:0]                      schemeSelect,
   input  wire logic                            configDone,
   input  wire logic                            configError,
   output logic                                 coreReset,
   output logic                                 configEnable,
   output por_seq_pkg::cfg_scheme_t             activeScheme,
   output logic                                 configured,
   output logic                                 userOutputEnable
);
   import por_seq_pkg::*;

   // Synchronised supply status from the leaf module.
   supply_good_if status ();

   // Sequencer state and stretch counter.
   por_state_t       state;
   por_state_t       next_state;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] next_count;
   logic [CNT_W-1:0] target;            // Selected stretch length in cycles.
   logic             delaySelLatched;   // Select level caught when supplies came good.
   logic             next_delaySelLatched;
   cfg_scheme_t      scheme;            // Scheme frozen at reset release.
   cfg_scheme_t      next_scheme;

   // Mode straps are board pins, so they pass two flip-flops like the supplies.
   logic [1:0]       schemeStage1;      // First stage, read only by the second.
   logic [1:0]       schemeStage2;      // Only this stage is read by the sequencer.
   logic [1:0]       next_schemeStage1;
   logic [1:0]       next_schemeStage2;

   // Registered outputs and their next values.
   logic next_coreReset;
   logic next_configEnable;
   logic next_configured;
   logic next_userOutputEnable;

   // Only the five monitored supply-good lines enter; other rails have no port.
   supply_sync u_sync
   (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .supplyGoodRaw  (supplyGood),       // RL2
      .delaySelectRaw (reset_delay_select),
      .status         (status.source)
   );

   // Map the scheme selection onto the enumerated scheme type.
   function automatic cfg_scheme_t decode_scheme(input logic [1:0] sel);
      cfg_scheme_t s;
      s = cfg_scheme_t'(sel);
      return s;
   endfunction

   // Pick the stretch length. The select level is latched once as the supplies come good
   // so that a board strap changing late cannot shorten a pulse already begun.
   always_comb
   begin
      if (delaySelLatched)
      begin
         target = SHORT_CYC; // RL4
      end
      else
      begin
         target = LONG_CYC;  // RL3
      end
   end

   // Next-state logic for the sequencer, the counter and the outputs.
   always_comb
   begin
      next_state            = state;
      next_count            = count;
      next_delaySelLatched  = delaySelLatched;
      next_scheme           = scheme;
      next_coreReset        = 1'b1;
      next_configEnable     = 1'b0;
      next_configured       = 1'b0;
      next_userOutputEnable = 1'b0;
      if (!status.allGood)
      begin
         // Any supply drop takes everything back to hold at once.
         next_state = ST_HOLD;      // RL10
         next_count = CNT_RESET;    // RL10
      end
      else
      begin
         case (state)
            ST_HOLD:
            begin
               // Supplies just came good: capture select and begin counting.
               next_delaySelLatched = status.delaySelect;
               next_count           = CNT_RESET;
               next_state           = ST_STRETCH;
            end
            ST_STRETCH:
            begin
               // Reset stays asserted for the whole selected width.
               if (count >= target - CNT_W'(1))
               begin
                  next_state     = ST_UNCONFIG;
                  next_count     = CNT_RESET;
                  next_coreReset = 1'b0;
                  next_scheme    = decode_scheme(schemeStage2); // RL8
               end
               else
               begin
                  next_count = count + CNT_W'(1);
               end
            end
            ST_UNCONFIG:
            begin
               // Volatile storage: nothing is loaded yet, always start a load.
               next_coreReset    = 1'b0;
               next_configEnable = 1'b1;   // RL7
               next_state        = ST_CONFIGURING;
            end
            ST_CONFIGURING:
            begin
               next_coreReset    = 1'b0;
               next_configEnable = 1'b1;
               if (configError)
               begin
                  // A failed load restarts from unconfigured.
                  next_state = ST_UNCONFIG;
               end
               else if (configDone)
               begin
                  next_state            = ST_USER;
                  next_configEnable     = 1'b0;
                  next_configured       = 1'b1;
                  next_userOutputEnable = 1'b1; // RL9
               end
            end
            ST_USER:
            begin
               next_coreReset        = 1'b0;
               next_configured       = 1'b1;
               next_userOutputEnable = 1'b1;    // RL9
            end
            default:
            begin
               next_state = ST_HOLD;
            end
         endcase
      end
   end

   // Next values for the strap synchroniser; the first stage feeds only the second.
   always_comb
   begin
      next_schemeStage1 = schemeSelect;
      next_schemeStage2 = schemeStage1;
   end

   // Strap synchroniser registers. Straps are meant to be hard-wired, so two
   // plain flops per bit suffice; a strap moved during release may be caught
   // half-changed, which is a board fault this logic does not try to hide.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         schemeStage1 <= SCHEME_RESET;
         schemeStage2 <= SCHEME_RESET;
      end
      else
      begin
         schemeStage1 <= next_schemeStage1;
         schemeStage2 <= next_schemeStage2;
      end
   end

   // State registers; reset values hold the device in reset with outputs off.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         state            <= ST_HOLD;             // RL6
         count            <= CNT_RESET;
         delaySelLatched  <= 1'b0;
         scheme           <= SCHEME_FAST_PARALLEL;
         coreReset        <= 1'b1;                // RL6
         configEnable     <= 1'b0;
         configured       <= 1'b0;                // RL7
         userOutputEnable <= 1'b0;                // RL9
      end
      else
      begin
         state            <= next_state;
         count            <= next_count;
         delaySelLatched  <= next_delaySelLatched;
         scheme           <= next_scheme;
         coreReset        <= next_coreReset;      // RL1
         configEnable     <= next_configEnable;
         configured       <= next_configured;
         userOutputEnable <= next_userOutputEnable;
      end
   end

   // The scheme is a register, so this output is straight from a flip-flop.
   assign activeScheme = scheme;

endmodule

// file: src/por_seq_pkg.sv
// Shared constants and types for the power-on reset sequencer.
// Assumes a single 40 MHz system clock; no software-visible registers.
package por_seq_pkg;

   // System clock rate in kHz, used to turn milliseconds into cycles.
   localparam int unsigned CLK_KHZ = 40000;

   // Reset stretch widths in milliseconds, as printed.
   localparam int unsigned LONG_STRETCH_MS  = 100;
   localparam int unsigned SHORT_STRETCH_MS = 12;

   // Counter width: 100 ms at 40 MHz is 4,000,000 cycles, which fits in 22 bits.
   localparam int unsigned CNT_W = 22;

   // Derived cycle counts (whole cycles, exact at this rate).
   localparam logic [CNT_W-1:0] LONG_STRETCH_CYC  = CNT_W'(LONG_STRETCH_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] SHORT_STRETCH_CYC = CNT_W'(SHORT_STRETCH_MS * CLK_KHZ);

   // Counter value after reset.
   localparam logic [CNT_W-1:0] CNT_RESET = 22'h000000;

   // Number of monitored supplies and their bit positions in the good vector.
   localparam int unsigned NUM_SUPPLIES  = 5;
   localparam int unsigned SUP_CORE      = 0;
   localparam int unsigned SUP_SEL_CORE  = 1;
   localparam int unsigned SUP_PROG_PWR  = 2;
   localparam int unsigned SUP_PREDRIVER = 3;
   localparam int unsigned SUP_CFG_PINS  = 4;

   // Number of configuration schemes and their encodings.
   localparam int unsigned NUM_SCHEMES = 4;
   typedef enum logic [1:0]
   {
      SCHEME_FAST_PARALLEL = 2'b00,
      SCHEME_FAST_SERIAL   = 2'b01,
      SCHEME_PASSIVE_SER   = 2'b10,
      SCHEME_SCAN_PORT     = 2'b11
   } cfg_scheme_t;

   // Sequencer states.
   typedef enum logic [2:0]
   {
      ST_HOLD       = 3'b000,
      ST_STRETCH    = 3'b001,
      ST_UNCONFIG   = 3'b010,
      ST_CONFIGURING = 3'b011,
      ST_USER       = 3'b100
   } por_state_t;

   // Scheme register value after reset.
   localparam logic [1:0] SCHEME_RESET = 2'h0;

endpackage

// file: src/supply_good_if.sv
// Interface carrying the synchronised supply-good status between the
// synchroniser and the sequencer core. One clock domain only.
`timescale 1ns/100ps
interface supply_good_if;
   logic allGood;      // All five monitored supplies are good.
   logic delaySelect;  // Synchronised delay-select level.
   modport source (output allGood, output delaySelect);
   modport sink   (input allGood, input delaySelect);
endinterface

// file: src/supply_sync.sv
// Two-flop synchroniser for the monitored supply-good inputs and the
// delay-select pin. Assumes all inputs are asynchronous to sys_clk.
`timescale 1ns/100ps
module supply_sync
   import por_seq_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   input  wire logic [NUM_SUPPLIES-1:0] supplyGoodRaw,
   input  wire logic                    delaySelectRaw,
   supply_good_if.source                 status
);

   // First and second stages; the first stage feeds only the second.
   logic [NUM_SUPPLIES:0] stage1;
   logic [NUM_SUPPLIES:0] stage2;
   logic [NUM_SUPPLIES:0] next_stage1;
   logic [NUM_SUPPLIES:0] next_stage2;

   // Next values: shift the raw levels through the two stages.
   always_comb
   begin
      next_stage1 = {delaySelectRaw, supplyGoodRaw};
      next_stage2 = stage1;
   end

   // Registers clear to "not good" so reset is held from power-up.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         stage1 <= '0;
         stage2 <= '0;
      end
      else
      begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   // Reset is held while any monitored supply is low.
   assign status.allGood     = &stage2[NUM_SUPPLIES-1:0]; // RL1
   assign status.delaySelect = stage2[NUM_SUPPLIES];

endmodule

// file: sim/por_checker.sv
// Port checker for the power-on reset sequencer.
// Assumes the stretch counts are passed down from the bound sequencer.
`timescale 1ns/100ps
module por_checker
   import por_seq_pkg::*;
#(
   parameter logic [por_seq_pkg::CNT_W-1:0] LONG_CYC  = por_seq_pkg::LONG_STRETCH_CYC, // Long stretch in cycles.
   parameter logic [por_seq_pkg::CNT_W-1:0] SHORT_CYC = por_seq_pkg::SHORT_STRETCH_CYC // Short stretch in cycles.
)
(
   input wire logic                                 sys_clk,
   input wire logic                                 rst,
   input wire logic [por_seq_pkg::NUM_SUPPLIES-1:0] supplyGood,
   input wire logic                                 reset_delay_select,
   input wire logic [1:0]                           schemeSelect,
   input wire logic                                 configDone,
   input wire logic                                 configError,
   input wire logic                                 coreReset,
   input wire logic                                 configEnable,
   input wire por_seq_pkg::cfg_scheme_t             activeScheme,
   input wire logic                                 configured,
   input wire logic                                 userOutputEnable
);
   logic [22:0] goodRun;         // Edges seen with every supply good.
   logic [22:0] next_goodRun;    // Saturates, so it never wraps to zero.
   logic        goodDly1;        // Supply-good delayed like the first sync stage.
   logic        goodDly2;        // Supply-good delayed like the second sync stage.
   logic        selLatched;      // Select level at the edge the supplies came good.
   logic        next_goodDly1;
   logic        next_goodDly2;
   logic        next_selLatched;
   // A supply loss, seen through the same two stages, restarts the run, so the
   // run matches the stretch count on the way down as well as on the way up.
   always_comb
   begin
      next_goodDly1   = &supplyGood;
      next_goodDly2   = goodDly1;
      next_selLatched = selLatched;
      if (&supplyGood && !goodDly1)
         next_selLatched = reset_delay_select;
      next_goodRun = goodRun + 23'h000001;
      if (!goodDly2)
         next_goodRun = 23'h000000;
      else if (&goodRun)
         next_goodRun = goodRun;
   end
   // Register stage only.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         goodRun    <= 23'h000000;
         goodDly1   <= 1'b0;
         goodDly2   <= 1'b0;
         selLatched <= 1'b0;
      end
      else
      begin
         goodRun    <= next_goodRun;
         goodDly1   <= next_goodDly1;
         goodDly2   <= next_goodDly2;
         selLatched <= next_selLatched;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_loss_resets: assert property (!(&supplyGood) |-> ##4 coreReset)
      else $error("core reset not reasserted after supply loss");
   a_long_hold: assert property (!selLatched && goodRun < LONG_CYC |-> coreReset)
      else $error("long stretch released early");
   a_short_hold: assert property (selLatched && goodRun < SHORT_CYC |-> coreReset)
      else $error("short stretch released early");
   a_short_release: assert property ($fell(coreReset) && selLatched |->
      goodRun >= SHORT_CYC && goodRun <= SHORT_CYC + 23'h000008)
      else $error("short stretch released late");
   a_long_release: assert property ($fell(coreReset) && !selLatched |->
      goodRun >= LONG_CYC && goodRun <= LONG_CYC + 23'h000008)
      else $error("long stretch released late");
   a_enable_follows: assert property ($fell(coreReset) |=> configEnable)
      else $error("configuration not enabled after release");
   a_reset_quiet: assert property (coreReset |-> !configEnable && !configured && !userOutputEnable)
      else $error("outputs active during reset");
   a_user_gated: assert property (userOutputEnable |-> configured && !configEnable)
      else $error("outputs enabled outside user mode");
   a_done_to_user: assert property (configEnable && configDone |=> userOutputEnable && !configEnable)
      else $error("done did not enter user mode");
   a_scheme_latch: assert property ($fell(coreReset) |-> activeScheme == schemeSelect)
      else $error("scheme not latched at release");
   a_scheme_hold: assert property (!coreReset && !$past(coreReset) |-> $stable(activeScheme))
      else $error("scheme changed after release");
   c_release: cover property ($fell(coreReset));
   c_error: cover property (configEnable && configError);
   c_user: cover property ($rose(userOutputEnable));
endmodule

// file: sim/board_model.sv
// Board model: supply rails and the configuration source.
// Assumes the bench switches rails and faults after clock edges.
`timescale 1ns/100ps
module board_model
   import por_seq_pkg::*;
#(
   parameter int unsigned LOAD_CYC  = 20, // Bitstream length in cycles.
   parameter int unsigned FLASH_CYC = 64  // Flash power-up wait in cycles.
)
(
   input  wire logic                                 sys_clk,
   input  wire logic [por_seq_pkg::NUM_SUPPLIES-1:0] rails,
   input  wire logic                                 failOnce,
   input  wire logic                                 configEnable,
   output logic      [por_seq_pkg::NUM_SUPPLIES-1:0] supplyGood,
   output logic                                      configDone,
   output logic                                      configError
);
   int   age = 0;     // Cycles since every rail came up.
   int   loadCnt = 0; // Cycles spent streaming.
   logic failed = 0;  // A corrupt load was already sent.
   logic errNow;      // Error decided this edge.
   initial
   begin
      supplyGood = '0;
      configDone = 1'b0;
      configError = 1'b0;
   end
   // Loading waits until the flash has finished its own power-up.
   always @(posedge sys_clk)
   begin
      age = (&supplyGood) ? age + 1 : 0;
      loadCnt = (configEnable && age >= FLASH_CYC) ? loadCnt + 1 : 0;
      failed = failed && failOnce;
      errNow = (loadCnt == LOAD_CYC) && failOnce && !failed;
      if (errNow)
      begin
         failed = 1'b1;
         loadCnt = 0;
      end
      supplyGood <= #1 rails;
      configError <= #1 errNow;
      configDone <= #1 configEnable && (configDone || loadCnt == LOAD_CYC);
   end
endmodule

// file: sim/tb_top.sv
// Top bench for the reset sequencer with the board model.
// Assumes scaled stretch counts, so both widths run in full.
`timescale 1ns/100ps
module tb_top;
   import por_seq_pkg::*;
   typedef struct packed {
      cfg_scheme_t scheme;    // Mode pins presented.
      logic        fail;      // Corrupt the first load.
      logic [1:0]  expScheme; // Mode expected after release.
   } row_t;
   localparam row_t ROWS [0:3] = '{'{SCHEME_FAST_PARALLEL, 1'b0, 2'h0}, '{SCHEME_FAST_SERIAL, 1'b1, 2'h1},
      '{SCHEME_PASSIVE_SER, 1'b0, 2'h2}, '{SCHEME_SCAN_PORT, 1'b1, 2'h3}};
   logic sys_clk, rst, reset_delay_select, failOnce, coreReset, configEnable, configured, userOutputEnable;
   logic configDone, configError;
   logic [NUM_SUPPLIES-1:0] rails, supplyGood;
   logic [1:0]              schemeSelect;
   cfg_scheme_t             activeScheme;
   // Stretch counts as for a 10 kHz clock: 12 ms and 100 ms keep their ratio but stay short.
   localparam logic [CNT_W-1:0] SHORT_SIM = 22'h000078;
   localparam logic [CNT_W-1:0] LONG_SIM  = 22'h0003e8;
   int mismatches = 0, total_checks = 0, errSeen = 0, e0, c;
   power_on_reset_sequencer #(.LONG_CYC(LONG_SIM), .SHORT_CYC(SHORT_SIM))
      power_on_reset_sequencer_inst (.sys_clk, .rst, .supplyGood, .reset_delay_select,
      .schemeSelect, .configDone, .configError, .coreReset, .configEnable, .activeScheme, .configured,
      .userOutputEnable);
   board_model board_model_inst (.sys_clk, .rails, .failOnce, .configEnable, .supplyGood, .configDone,
      .configError);
   // Clock at 25 ns.
   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Counts error pulses from the source.
   always @(posedge sys_clk)
      if (configError === 1'b1)
         errSeen++;
   // Inputs change 1 ns after an edge, never on it.
   task automatic tick(int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Bounded wait for release; the bound is a little over one long stretch.
   task automatic waitRel(output int n);
      n = 0;
      while (coreReset !== 1'b0 && n < 1100)
      begin
         tick(1);
         n++;
      end
   endtask
   // Release must land a few sync cycles after the selected count.
   function automatic logic inWin(int n, int t);
      return n >= t + 2 && n <= t + 8;
   endfunction
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hang; a clean run takes about 3,000 cycles.
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      print_verdict();
   end
   // Main sequence: table rows first, then restart and long stretch.
   initial
   begin
      {rst, reset_delay_select, failOnce, rails, schemeSelect} = {3'b110, 5'h00, 2'h0};
      tick(8);
      rst = 1'b0;
      tick(1);
      check("rstCore", {coreReset, configEnable, userOutputEnable, activeScheme}, 5'h10);
      foreach (ROWS[i])
      begin
         schemeSelect = ROWS[i].scheme;
         failOnce = ROWS[i].fail;
         e0 = errSeen;
         rails = '1;
         waitRel(c);
         check("width", inWin(c, SHORT_SIM), 1);
         check("scheme", activeScheme, ROWS[i].expScheme);
         for (int k = 0; k < 400 && configured !== 1'b1; k++)
            tick(1);
         check("outEnable", userOutputEnable, 1);
         check("errors", errSeen - e0, ROWS[i].fail);
         rails[i] = 1'b0;
         tick(5);
         check("dropped", {coreReset, userOutputEnable}, 2'h2);
         rails = '0;
         tick(5);
      end
      rails = '1;
      tick(SHORT_SIM / 2);
      rails[4] = 1'b0;
      tick(4);
      check("midStretch", coreReset, 1);
      rails = '1;
      waitRel(c);
      check("restart", inWin(c, SHORT_SIM), 1);
      rails = '0;
      reset_delay_select = 1'b0;
      tick(5);
      rails = '1;
      tick(SHORT_SIM + 50);
      check("longHold", {coreReset, configEnable}, 2'h2);
      waitRel(c);
      check("longRel", inWin(c + SHORT_SIM + 50, LONG_SIM), 1);
      // Reset in mid-run with supplies good: core reset reasserts, the enables drop, then a full stretch.
      rst = 1'b1;
      tick(2);
      check("midReset", {coreReset, configEnable, configured, userOutputEnable}, 4'h8);
      rst = 1'b0;
      waitRel(c);
      check("afterReset", inWin(c, LONG_SIM), 1);
      print_verdict();
   end
endmodule
// The stretch counts come from each bound instance, so the checker follows any override.
bind power_on_reset_sequencer por_checker #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC))
   por_checker_inst (.sys_clk, .rst, .supplyGood, .reset_delay_select,
   .schemeSelect, .configDone, .configError, .coreReset, .configEnable, .activeScheme, .configured,
   .userOutputEnable);
